// >>> cpu_seq_model.sv
`default_nettype none

module cpu_seq_model
(
    input  wire logic clk_sys_i,
    input  wire logic resetn_i,
    input  wire logic slow_i,
    input  wire logic busy_i,
    output logic      instr_end_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt_reg;

    // Never ends an instruction while the save sequence runs
    assign instr_end_o = resetn_i && !busy_i && (!slow_i || cnt_reg == 6'h00);

    // Slow mode stands in for a long divide: 48 cycles an instruction
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_reg <= 6'h00;
        else if (instr_end_o && slow_i)
            cnt_reg <= 6'h2F;
        else if (cnt_reg != 6'h00)
            cnt_reg <= cnt_reg - 6'h01;
    end
endmodule : cpu_seq_model

`default_nettype wire

// >>> interrupt_acknowledge_nesting.sv
// Operation
// R01 - Eligible only when requested and not masked
// R02 - Maskable acknowledge only with accept enable set
// R03 - High handler running blocks low priority requests
// R04 - Minimum latency 13 high, 15 low clocks
// R05 - Maximum latency 63 high, 65 low clocks
// R06 - Priority flag first, then default order
// R07 - Push status, PC; clear enable; load vector
// R08 - Vectored return ends a maskable handler; the code only clears the non-maskable in-service flag on it
// R09 - Returns and status pop restore status word
// R10 - Break trap always taken, vector 003EH/003FH
// R11 - Break handler leaves by break return
// R12 - Nest equal or higher priority, not lower
// R13 - Held request taken after one main instruction
// R14 - Nothing nests during non-maskable handler; the code still takes the break trap there
// R15 - Non-maskable taken despite cleared accept enable
// R16 - Status and flag touching instructions defer acknowledge
// R17 - Break trap itself does not defer
// R18 - Request flag set ignores priority flag
// R19 - Test events set flag, release standby
// R20 - Key input on any port falling edge
// R21 - Test events never start vectored processing
// R22 - Standby release only when test unmasked
// R23 - Default order and vectors are parameters
`include "irq_nest_cfg.svh"
`default_nettype none

module interrupt_acknowledge_nesting
    import irq_nest_pkg::*;
#(
    parameter logic [`NUM_SRC*`SRC_IDX_W-1:0] DEF_ORDER = 48'hBA9876543210,
    parameter logic [15:0]                    VEC_BASE  = 16'h0006,
    parameter logic [15:0]                    NMI_VEC   = 16'h0004
)
(
    input  wire logic                   clk_sys_i,
    input  wire logic                   resetn_i,
    input  wire logic [`NUM_SRC-1:0]    src_req_i,
    input  wire logic                   flag_wr_i,
    input  wire logic [`NUM_SRC-1:0]    flag_wdata_i,
    input  wire logic [`NUM_SRC-1:0]    mask_flag_i,
    input  wire logic [`NUM_SRC-1:0]    priority_select_flag_i,
    input  wire logic                   nmi_req_i,
    input  wire logic                   instr_end_i,
    input  wire logic                   instr_defer_i,
    input  wire logic                   break_trap_instr_i,
    input  wire logic                   vectored_return_instr_i,
    input  wire logic                   status_restore_i,
    input  wire logic                   restore_en_i,
    input  wire logic                   restore_svc_i,
    input  wire logic                   accept_on_instr_i,
    input  wire logic                   accept_off_instr_i,
    input  wire logic                   watch_overflow_test_input_i,
    input  wire logic [`KEY_W-1:0]      key_port_i,
    input  wire logic                   watch_test_mask_i,
    input  wire logic                   key_return_test_mask_i,
    input  wire logic                   test_flag_wr_i,
    input  wire logic                   watch_test_flag_wdata_i,
    input  wire logic                   key_return_test_flag_wdata_i,
    output logic [`NUM_SRC-1:0]         request_flag_o,
    output logic                        global_accept_enable_o,
    output logic                        in_service_priority_o,
    output logic                        nmi_in_service_o,
    output logic                        ack_busy_o,
    output logic                        push_status_o,
    output logic                        push_pc_o,
    output logic                        vector_load_o,
    output logic [15:0]                 vector_addr_o,
    output logic [`SRC_IDX_W-1:0]       ack_source_o,
    output logic                        watch_test_flag_o,
    output logic                        key_return_test_flag_o,
    output logic                        standby_release_o
);

    // Returns {found, index} of the best candidate in default order
    function automatic logic [`SRC_IDX_W:0] pick_src(
        input logic [`NUM_SRC-1:0] cand
    );
        logic [`SRC_IDX_W:0]   res;
        logic [`SRC_IDX_W-1:0] idx;
        res = '0;
        for (int r = `NUM_SRC - 1; r >= 0; r--)
        begin
            idx = DEF_ORDER[r*`SRC_IDX_W +: `SRC_IDX_W];
            if (cand[idx])
            begin
                res = {1'b1, idx}; // R06
            end
        end
        return res;
    endfunction : pick_src

    logic [`NUM_SRC-1:0]   flag_reg;
    logic [`NUM_SRC-1:0]   flag_next;
    logic [`AGE_W-1:0]     age_reg [`NUM_SRC];
    logic [`NUM_SRC-1:0]   aged;
    logic                  en_reg;
    logic                  en_next;
    logic                  svc_reg;
    logic                  svc_next;
    logic                  nmi_pend_reg;
    logic                  nmi_pend_next;
    logic                  nmi_svc_reg;
    logic                  nmi_svc_next;
    seq_state_t            state_reg;
    seq_state_t            state_next;
    ack_kind_t             kind_reg;
    ack_kind_t             kind_next;
    logic [`SRC_IDX_W-1:0] src_reg;
    logic [`SRC_IDX_W-1:0] src_next;
    logic [15:0]           vec_reg;
    logic [15:0]           vec_next;
    logic                  push_status_reg;
    logic                  push_pc_reg;
    logic                  vector_load_reg;
    logic                  busy_reg;
    logic [`KEY_W-1:0]     key_prev_reg;
    logic                  wt_flag_reg;
    logic                  wt_flag_next;
    logic                  kr_flag_reg;
    logic                  kr_flag_next;
    logic                  release_reg;
    logic                  release_next;

    logic [`NUM_SRC-1:0]   cand;
    logic [`SRC_IDX_W:0]   pick_hi;
    logic [`SRC_IDX_W:0]   pick_lo;
    logic                  idle;
    logic                  boundary;
    logic                  take_brk;
    logic                  take_nmi;
    logic                  take_mask;
    logic [`SRC_IDX_W-1:0] mask_idx;
    logic                  key_fall;

    // Age gates eligibility so service never starts before the minimum
    generate
        for (genvar i = 0; i < `NUM_SRC; i++)
        begin : g_age
            logic [`AGE_W-1:0] age_next;
            always_comb
            begin
                age_next = age_reg[i];
                if (!flag_reg[i])
                begin
                    age_next = '0;
                end
                else if (age_reg[i] != `AGE_MAX)
                begin
                    age_next = age_reg[i] + 4'h1;
                end
            end
            always_ff @(posedge clk_sys_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    age_reg[i] <= '0;
                end
                else
                begin
                    age_reg[i] <= age_next;
                end
            end
            assign aged[i] = priority_select_flag_i[i] ?
                             (age_reg[i] >= `AGE_LO) :
                             (age_reg[i] >= `AGE_HI); // R04
        end
    endgenerate

    assign cand = flag_reg & ~mask_flag_i & aged // R01
                & (~priority_select_flag_i | {`NUM_SRC{svc_reg}}); // R03 R12
    assign pick_hi = pick_src(cand & ~priority_select_flag_i);
    assign pick_lo = pick_src(cand & priority_select_flag_i);
    assign mask_idx = pick_hi[`SRC_IDX_W] ? pick_hi[`SRC_IDX_W-1:0]
                                          : pick_lo[`SRC_IDX_W-1:0]; // R06

    // Decision only at instruction ends; the longest instruction bounds
    // the wait, so the sequencer must not exceed the upper latency
    assign idle     = (state_reg == ST_IDLE);
    // Judged on the ending one, so a deferring instruction lets one more run
    assign boundary = instr_end_i & idle & ~instr_defer_i; // R05 R13 R16
    assign take_brk = instr_end_i & idle & break_trap_instr_i; // R10 R17
    assign take_nmi = boundary & ~break_trap_instr_i & nmi_pend_reg
                    & ~nmi_svc_reg; // R14 R15
    assign take_mask = boundary & ~break_trap_instr_i & ~nmi_pend_reg
                     & ~nmi_svc_reg & en_reg // R02 R14
                     & (pick_hi[`SRC_IDX_W] | pick_lo[`SRC_IDX_W]);

    always_comb
    begin
        flag_next = flag_wr_i ? flag_wdata_i : flag_reg;
        if (take_mask)
        begin
            flag_next[mask_idx] = 1'b0;
        end
        flag_next = flag_next | src_req_i; // R18
    end

    always_comb
    begin
        en_next       = en_reg;
        svc_next      = svc_reg;
        nmi_svc_next  = nmi_svc_reg;
        nmi_pend_next = (nmi_pend_reg & ~take_nmi) | nmi_req_i;
        if (state_reg == ST_PUSH_PC)
        begin
            // Cleared only after the status push so the old value is saved
            en_next = 1'b0; // R07 R10
            if (kind_reg == KIND_MASKABLE)
            begin
                svc_next = priority_select_flag_i[src_reg]; // R07
            end
            else if (kind_reg == KIND_NMI)
            begin
                svc_next     = 1'b0;
                nmi_svc_next = 1'b1;
            end
        end
        else if (status_restore_i)
        begin
            en_next  = restore_en_i; // R09
            svc_next = restore_svc_i; // R09
        end
        else if (accept_on_instr_i)
        begin
            en_next = 1'b1;
        end
        else if (accept_off_instr_i)
        begin
            en_next = 1'b0;
        end
        if (vectored_return_instr_i)
        begin
            nmi_svc_next = 1'b0; // R08
        end
    end

    always_comb
    begin
        state_next = state_reg;
        kind_next  = kind_reg;
        src_next   = src_reg;
        vec_next   = vec_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (take_brk)
                begin
                    state_next = ST_PUSH_STATUS;
                    kind_next  = KIND_BREAK;
                end
                else if (take_nmi)
                begin
                    state_next = ST_PUSH_STATUS;
                    kind_next  = KIND_NMI;
                end
                else if (take_mask)
                begin
                    state_next = ST_PUSH_STATUS;
                    kind_next  = KIND_MASKABLE;
                    src_next   = mask_idx;
                end
            end
            ST_PUSH_STATUS:
            begin
                state_next = ST_PUSH_PC; // R07
            end
            ST_PUSH_PC:
            begin
                state_next = ST_LOAD_VEC;
                case (kind_reg)
                    KIND_BREAK:
                    begin
                        vec_next = `TRAP_VEC_LO; // R10
                    end
                    KIND_NMI:
                    begin
                        vec_next = NMI_VEC;
                    end
                    default:
                    begin
                        vec_next = VEC_BASE
                                 + 16'(src_reg) * `VEC_STEP; // R07 R23
                    end
                endcase
            end
            ST_LOAD_VEC:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Test inputs touch no vector path, only their flag and standby
    assign key_fall = |(key_prev_reg & ~key_port_i); // R20

    always_comb
    begin
        wt_flag_next = test_flag_wr_i ? watch_test_flag_wdata_i
                                      : wt_flag_reg;
        kr_flag_next = test_flag_wr_i ? key_return_test_flag_wdata_i
                                      : kr_flag_reg;
        wt_flag_next = wt_flag_next | watch_overflow_test_input_i; // R19
        kr_flag_next = kr_flag_next | key_fall; // R19
        release_next = (watch_overflow_test_input_i & ~watch_test_mask_i)
                     | (key_fall & ~key_return_test_mask_i); // R22 R21
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            flag_reg        <= `FLAG_RST;
            en_reg          <= `EN_RST;
            svc_reg         <= `SVC_RST;
            nmi_pend_reg    <= 1'b0;
            nmi_svc_reg     <= 1'b0;
            state_reg       <= ST_IDLE;
            kind_reg        <= KIND_MASKABLE;
            src_reg         <= '0;
            vec_reg         <= '0;
            push_status_reg <= 1'b0;
            push_pc_reg     <= 1'b0;
            vector_load_reg <= 1'b0;
            busy_reg        <= 1'b0;
            key_prev_reg    <= `KEY_PREV_RST;
            wt_flag_reg     <= 1'b0;
            kr_flag_reg     <= 1'b0;
            release_reg     <= 1'b0;
        end
        else
        begin
            flag_reg        <= flag_next;
            en_reg          <= en_next;
            svc_reg         <= svc_next;
            nmi_pend_reg    <= nmi_pend_next;
            nmi_svc_reg     <= nmi_svc_next;
            state_reg       <= state_next;
            kind_reg        <= kind_next;
            src_reg         <= src_next;
            vec_reg         <= vec_next;
            push_status_reg <= (state_next == ST_PUSH_STATUS);
            push_pc_reg     <= (state_next == ST_PUSH_PC);
            vector_load_reg <= (state_next == ST_LOAD_VEC);
            busy_reg        <= (state_next != ST_IDLE);
            key_prev_reg    <= key_port_i;
            wt_flag_reg     <= wt_flag_next;
            kr_flag_reg     <= kr_flag_next;
            release_reg     <= release_next;
        end
    end

    assign request_flag_o         = flag_reg;
    assign global_accept_enable_o = en_reg;
    assign in_service_priority_o  = svc_reg;
    assign nmi_in_service_o       = nmi_svc_reg;
    assign ack_busy_o             = busy_reg;
    assign push_status_o          = push_status_reg;
    assign push_pc_o              = push_pc_reg;
    assign vector_load_o          = vector_load_reg;
    assign vector_addr_o          = vec_reg;
    assign ack_source_o           = src_reg;
    assign watch_test_flag_o      = wt_flag_reg;
    assign key_return_test_flag_o = kr_flag_reg;
    assign standby_release_o      = release_reg;

endmodule : interrupt_acknowledge_nesting

`default_nettype wire

// >>> interrupt_acknowledge_nesting_asserts.sv
`include "irq_nest_cfg.svh"
`default_nettype none

module interrupt_acknowledge_nesting_asserts
    import irq_nest_pkg::*;
#(
    parameter logic [15:0] NMI_VEC = 16'h0004
)
(
    input wire logic                clk_sys_i,
    input wire logic                resetn_i,
    input wire logic [`NUM_SRC-1:0] src_req_i,
    input wire logic                instr_end_i,
    input wire logic                break_trap_instr_i,
    input wire logic                watch_overflow_test_input_i,
    input wire logic [`KEY_W-1:0]   key_port_i,
    input wire logic                watch_test_mask_i,
    input wire logic                key_return_test_mask_i,
    input wire logic [`NUM_SRC-1:0] request_flag_o,
    input wire logic                global_accept_enable_o,
    input wire logic                nmi_in_service_o,
    input wire logic                ack_busy_o,
    input wire logic                push_status_o,
    input wire logic                push_pc_o,
    input wire logic                vector_load_o,
    input wire logic [15:0]         vector_addr_o,
    input wire logic                watch_test_flag_o,
    input wire logic                key_return_test_flag_o,
    input wire logic                standby_release_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`KEY_W-1:0] key_q_reg;
    logic              key_fall;
    logic              wake;

    // History starts at all ones so a pin low at release counts as a falling edge
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            key_q_reg <= `KEY_PREV_RST;
        else
            key_q_reg <= key_port_i;
    end
    assign key_fall = |(key_q_reg & ~key_port_i);
    assign wake = (watch_overflow_test_input_i & ~watch_test_mask_i)
                | (key_fall & ~key_return_test_mask_i);

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    property p_seq;
        $rose(ack_busy_o) |-> push_status_o ##1 (push_pc_o && ack_busy_o)
            ##1 (vector_load_o && ack_busy_o) ##1 !ack_busy_o;
    endproperty
    a_seq: assert property (p_seq) else $error("save order wrong");
    property p_ie;
        vector_load_o |-> !global_accept_enable_o;
    endproperty
    a_ie: assert property (p_ie) else $error("enable not cleared");
    property p_brk;
        instr_end_i && break_trap_instr_i && !ack_busy_o
            |-> ##3 (vector_load_o && vector_addr_o == `TRAP_VEC_LO);
    endproperty
    a_brk: assert property (p_brk) else $error("trap not taken");
    property p_flag;
        |src_req_i |=> (request_flag_o & $past(src_req_i)) == $past(src_req_i);
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_key;
        key_fall |=> key_return_test_flag_o;
    endproperty
    a_key: assert property (p_key) else $error("key flag missed");
    property p_watch;
        watch_overflow_test_input_i |=> watch_test_flag_o;
    endproperty
    a_watch: assert property (p_watch) else $error("watch flag missed");
    property p_wake;
        standby_release_o |-> $past(wake);
    endproperty
    a_wake: assert property (p_wake) else $error("stray release");
    property p_nmi_nest;
        nmi_in_service_o && !$past(instr_end_i && break_trap_instr_i)
            |-> !push_status_o;
    endproperty
    a_nmi_nest: assert property (p_nmi_nest) else $error("nested");
    property p_nmi_vec;
        $rose(nmi_in_service_o) |-> vector_load_o && vector_addr_o == NMI_VEC;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("bad nmi");

    c_brk: cover property (vector_load_o && vector_addr_o == `TRAP_VEC_LO);
    c_nmi: cover property ($rose(nmi_in_service_o));
    c_wake: cover property (standby_release_o);
endmodule : interrupt_acknowledge_nesting_asserts

bind interrupt_acknowledge_nesting interrupt_acknowledge_nesting_asserts
    #(.NMI_VEC(NMI_VEC)) asserts_u (.*);

`default_nettype wire

// >>> interrupt_acknowledge_nesting_tb.sv
`default_nettype none

module interrupt_acknowledge_nesting_tb
    import irq_nest_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] VB = 16'h0006;
    localparam logic [15:0] NV = 16'h0004;
    typedef struct {logic [3:0] s; logic p; logic m; int lat;} row_t;
    logic clk_sys_i, resetn_i, flag_wr_i, nmi_req_i, instr_end_i, slow;
    logic instr_defer_i, break_trap_instr_i, vectored_return_instr_i;
    logic status_restore_i, restore_en_i, restore_svc_i, test_flag_wr_i;
    logic accept_on_instr_i, accept_off_instr_i, watch_test_mask_i;
    logic watch_overflow_test_input_i, key_return_test_mask_i;
    logic watch_test_flag_wdata_i, key_return_test_flag_wdata_i;
    logic global_accept_enable_o, in_service_priority_o, nmi_in_service_o;
    logic ack_busy_o, push_status_o, push_pc_o, vector_load_o;
    logic watch_test_flag_o, key_return_test_flag_o, standby_release_o;
    logic [11:0] src_req_i, flag_wdata_i, mask_flag_i;
    logic [11:0] priority_select_flag_i, request_flag_o;
    logic [7:0]  key_port_i;
    logic [15:0] vector_addr_o;
    logic [3:0]  ack_source_o;
    int          miscompares = 0, checks = 0, pushes = 0, n, p0;
    row_t rows [5] = '{'{4'h5, 1'b0, 1'b1, 0}, '{4'h7, 1'b1, 1'b1, 0},
        '{4'h2, 1'b0, 1'b0, 13}, '{4'hB, 1'b0, 1'b0, 13},
        '{4'h0, 1'b1, 1'b0, 15}};

    interrupt_acknowledge_nesting #(.VEC_BASE(VB), .NMI_VEC(NV)) dut_u (.*);
    cpu_seq_model seq_u (.clk_sys_i, .resetn_i, .slow_i(slow),
        .busy_i(ack_busy_o), .instr_end_o(instr_end_i));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) if (push_status_o === 1'b1) pushes++;

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #2;
    endtask : step
    task automatic chk(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic pulse(ref logic x);
        x = 1'b1;
        step(1);
        x = 1'b0;
    endtask : pulse
    task automatic req(input logic [3:0] s);
        src_req_i = 12'h001 << s;
        step(1);
        src_req_i = 12'h000;
        chk("flag", 16'h1, 16'(request_flag_o[s]));
    endtask : req
    task automatic wait_load(input int lim);
        for (n = 0; n < lim && vector_load_o !== 1'b1; n++)
            step(1);
        if (vector_load_o !== 1'b1)
        begin
            miscompares++;
            end_sim();
        end
    endtask : wait_load
    task automatic take(input logic [3:0] s, input int lim);
        wait_load(lim);
        chk("vector", VB + {11'h000, s, 1'b0}, vector_addr_o);
        chk("source", 16'(s), 16'(ack_source_o));
        chk("enable", 16'h0, 16'(global_accept_enable_o));
        chk("cleared", 16'h0, 16'(request_flag_o[s]));
    endtask : take
    task automatic ret(input logic en, input logic svc, input logic vr);
        {restore_en_i, restore_svc_i} = {en, svc};
        {status_restore_i, vectored_return_instr_i} = {1'b1, vr};
        instr_defer_i = 1'b1;
        step(1);
        {status_restore_i, vectored_return_instr_i, instr_defer_i} = 3'b000;
    endtask : ret

    initial
    begin
        {resetn_i, flag_wr_i, nmi_req_i, instr_defer_i, break_trap_instr_i,
            vectored_return_instr_i, status_restore_i, restore_en_i, slow,
            restore_svc_i, accept_on_instr_i, accept_off_instr_i,
            test_flag_wr_i, watch_overflow_test_input_i, watch_test_mask_i,
            key_return_test_mask_i, watch_test_flag_wdata_i,
            key_return_test_flag_wdata_i} = '0;
        {src_req_i, flag_wdata_i, priority_select_flag_i} = '0;
        mask_flag_i = 12'hFFF;
        key_port_i = 8'hFF;
        step(5);
        resetn_i = 1'b1;
        chk("svc", 16'h1, 16'(in_service_priority_o));
        chk("idle", 16'h0,
            {2'b00, global_accept_enable_o, ack_busy_o, request_flag_o});
        foreach (rows[i])
        begin
            mask_flag_i = 12'hFFF;
            mask_flag_i[rows[i].s] = rows[i].m;
            priority_select_flag_i[rows[i].s] = rows[i].p;
            pulse(accept_on_instr_i);
            p0 = pushes;
            req(rows[i].s);
            if (rows[i].lat == 0)
            begin
                step(30);
                chk("pushes", 16'(p0), 16'(pushes));
                pulse(flag_wr_i);
            end
            else
            begin
                take(rows[i].s, 60);
                chk("latency", 16'(rows[i].lat), 16'(n + 1));
                chk("svc", 16'(rows[i].p), 16'(in_service_priority_o));
                ret(1'b0, 1'b1, 1'b1);
            end
        end
        pulse(accept_off_instr_i);
        {mask_flag_i, priority_select_flag_i} = {12'hFFB, 12'h000};
        p0 = pushes;
        req(4'h2);
        step(30);
        chk("pushes", 16'(p0), 16'(pushes));
        instr_defer_i = 1'b1;
        pulse(accept_on_instr_i);
        step(30);
        chk("pushes", 16'(p0), 16'(pushes));
        instr_defer_i = 1'b0;
        take(4'h2, 8);
        chk("defer", 16'h3, 16'(n));
        ret(1'b0, 1'b1, 1'b1);
        {mask_flag_i, priority_select_flag_i} = {12'h000, 12'h002};
        pulse(accept_on_instr_i);
        src_req_i = 12'h02A;
        step(1);
        src_req_i = 12'h000;
        take(4'h3, 30);
        pulse(accept_on_instr_i);
        take(4'h5, 10);
        p0 = pushes;
        pulse(accept_on_instr_i);
        step(30);
        chk("pushes", 16'(p0), 16'(pushes));
        ret(1'b1, 1'b1, 1'b1);
        take(4'h1, 10);
        chk("held", 16'h3, 16'(n));
        ret(1'b0, 1'b1, 1'b1);
        pulse(break_trap_instr_i);
        wait_load(5);
        chk("vector", 16'h003E, vector_addr_o);
        pulse(nmi_req_i);
        wait_load(10);
        chk("vector", NV, vector_addr_o);
        chk("nmi", 16'h1, 16'(nmi_in_service_o));
        mask_flag_i = 12'hFFB;
        pulse(accept_on_instr_i);
        p0 = pushes;
        req(4'h2);
        step(30);
        chk("pushes", 16'(p0), 16'(pushes));
        ret(1'b1, 1'b1, 1'b1);
        take(4'h2, 10);
        ret(1'b0, 1'b1, 1'b0);
        p0 = pushes;
        for (int m = 0; m < 2; m++)
        begin
            {key_return_test_mask_i, watch_test_mask_i} = {2{m[0]}};
            key_port_i = m[0] ? 8'h7F : 8'hFE;
            step(1);
            chk("key", 16'h1, 16'(key_return_test_flag_o));
            chk("wake", 16'(!m[0]), 16'(standby_release_o));
            key_port_i = 8'hFF;
            pulse(watch_overflow_test_input_i);
            chk("watch", 16'h1, 16'(watch_test_flag_o));
            chk("wake", 16'(!m[0]), 16'(standby_release_o));
            pulse(test_flag_wr_i);
            chk("key", 16'h0, 16'(key_return_test_flag_o));
            chk("watch", 16'h0, 16'(watch_test_flag_o));
        end
        chk("pushes", 16'(p0), 16'(pushes));
        pulse(accept_on_instr_i);
        slow = 1'b1;
        step(1);
        req(4'h2);
        take(4'h2, 62);
        end_sim();
    end
endmodule : interrupt_acknowledge_nesting_tb

`default_nettype wire

// >>> irq_nest_cfg.svh
`ifndef IRQ_NEST_CFG_SVH
`define IRQ_NEST_CFG_SVH

`define NUM_SRC        12
`define SRC_IDX_W      4
`define AGE_W          4
`define KEY_W          8
`define FLAG_RST       12'h000
`define EN_RST         1'b0
`define SVC_RST        1'b1
`define KEY_PREV_RST   8'hFF
`define LAT_MIN_HI     13
`define LAT_MIN_LO     15
`define LAT_MAX_HI     63
`define LAT_MAX_LO     65
`define SEQ_LEN        4
`define AGE_HI         4'(`LAT_MIN_HI - `SEQ_LEN)
`define AGE_LO         4'(`LAT_MIN_LO - `SEQ_LEN)
`define AGE_MAX        4'hF
`define TRAP_VEC_LO    16'h003E
`define TRAP_VEC_HI    16'h003F
`define VEC_STEP       16'h0002

`endif

// >>> irq_nest_pkg.sv
`default_nettype none

package irq_nest_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE        = 2'h0,
        ST_PUSH_STATUS = 2'h1,
        ST_PUSH_PC     = 2'h3,
        ST_LOAD_VEC    = 2'h2
    } seq_state_t;

    typedef enum logic [1:0]
    {
        KIND_MASKABLE = 2'h0,
        KIND_BREAK    = 2'h1,
        KIND_NMI      = 2'h2
    } ack_kind_t;

endpackage : irq_nest_pkg

`default_nettype wire
